/* File: design/tpu_timer.sv */
// Purpose: multi-channel 16-bit timer with capture, compare and PWM
// Assumes: one clock, synchronous active-high reset, AXI4-Lite registers
// Notes:   channel pins are split into input, output and output enable
//
// How it works
// - channels capture, compare or PWM on one counter
// - prescaler divides by 1 to 128
// - clock select: none, bus, fixed, external
// - fixed and external clocks synchronised first
// - capture edge copies counter, sets flag
// - capture edge rising, falling, either or none
// - compare match sets flag, drives pin action
// - edge PWM period is modulo plus one
// - edge PWM leading edge at period start
// - flags at period end and duty point
// - center mode counts up then down
// - center active on down match, inactive up
// - center bit overrides all channel modes
// - debug halt freezes counting
// - modulo zero or all ones free runs
// - counter read harmless, write resets counter
// - one event per channel plus overflow
// - after reset pins stay with port logic
// - edge field zero still compares as timer
// - mode 00 capture, 01 compare, 1x PWM
// - edge PWM polarity from low select bit
// - PWM value loads at step into top
`timescale 1ns/10ps
`default_nettype none
module tpu_timer (
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_rst,
  input  wire tpu_pkg::tpu_axi_req_t       i_axi,
  output tpu_pkg::tpu_axi_rsp_t            o_axi,
  input  wire logic                        i_debug_halt,
  input  wire logic                        i_fixed_clk,
  input  wire logic                        i_ext_clk,
  input  wire logic [tpu_pkg::NUM_CH-1:0]  i_ch_pin,
  output logic      [tpu_pkg::NUM_CH-1:0]  o_ch_pin,
  output logic      [tpu_pkg::NUM_CH-1:0]  o_ch_oe,
  output logic                             o_ovf_irq,
  output logic      [tpu_pkg::NUM_CH-1:0]  o_ch_irq
);
  // ****************************************
  // state
  // ****************************************
  tpu_pkg::tpu_state_t          st;
  tpu_pkg::tpu_state_t          next_st;
  logic                         wr_fire;
  logic                         rd_fire;
  logic                         src_tick;
  logic                         tick;
  logic [tpu_pkg::CNT_W-1:0]    top;
  logic [tpu_pkg::PRE_W-1:0]    pmask;
  logic [tpu_pkg::CNT_W-1:0]    cnt_next;

  assign wr_fire = st.aw_got & st.w_got & (st.bstate == tpu_pkg::TPU_IDLE);
  assign rd_fire = i_axi.arvalid & ~st.rvalid;

  // ****************************************
  // read decode
  // ****************************************
  function automatic logic [32:0] rd_word(input tpu_pkg::tpu_state_t s,
                                          input logic [tpu_pkg::ADDR_W-1:0] a);
    logic [32:0] r;
    logic [tpu_pkg::ADDR_W-1:0] off;
    r = {1'b1, 32'h00000000};
    if (a == tpu_pkg::OFF_SC) begin
      r = {1'b0, 24'h000000, s.tof, s.toie, s.center_aligned_pwm, s.clk_sel, s.ps};
    end else if (a == tpu_pkg::OFF_CNT) begin
      r = {1'b0, 16'h0000, s.cnt};
    end else if (a == tpu_pkg::OFF_MOD) begin
      r = {1'b0, 16'h0000, s.modv};
    end else begin
      for (int n = 0; n < tpu_pkg::NUM_CH; n++) begin
        off = tpu_pkg::OFF_CH_BASE + tpu_pkg::ADDR_W'(n) * tpu_pkg::OFF_CH_STEP;
        if (a == off) begin
          r = {1'b0, 24'h000000, s.ch[n].flag, s.ch[n].ie, s.ch[n].mode, s.ch[n].els,
               2'h0};
        end else if (a == off + tpu_pkg::OFF_CH_VAL) begin
          r = {1'b0, 16'h0000, s.ch[n].val};
        end
      end
    end
    return r;
  endfunction : rd_word

  // ****************************************
  // counter clocking
  // ****************************************
  always_comb begin
    unique case (st.clk_sel)
      tpu_pkg::CLK_BUS: src_tick = 1'b1;
      tpu_pkg::CLK_FIX: src_tick = st.fix_sync[1] & ~st.fix_sync[2];
      tpu_pkg::CLK_EXT: src_tick = st.ext_sync[1] & ~st.ext_sync[2];
      default:          src_tick = 1'b0;
    endcase
    pmask = tpu_pkg::PRE_W'((8'h01 << st.ps) - 8'h01);
    tick  = src_tick & ((st.pre & pmask) == pmask) & ~i_debug_halt;
    top   = (st.modv == tpu_pkg::CNT_ZERO) ? tpu_pkg::CNT_FULL : st.modv;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [32:0]               rd;
    logic [tpu_pkg::ADDR_W-1:0] off;
    logic                      wr_hit;
    logic                      pin_r;
    logic                      pin_f;
    logic                      hit;
    logic                      pwm_load;
    logic                      tof_set;
    logic [tpu_pkg::NUM_CH-1:0] ch_set;
    rd       = 33'h000000000;
    off      = 8'h00;
    wr_hit   = 1'b0;
    pin_r    = 1'b0;
    pin_f    = 1'b0;
    hit      = 1'b0;
    pwm_load = 1'b0;
    tof_set  = 1'b0;
    ch_set   = '0;
    cnt_next = st.cnt;
    next_st  = st;
    next_st.ext_sync = {st.ext_sync[1:0], i_ext_clk};
    next_st.fix_sync = {st.fix_sync[1:0], i_fixed_clk};
    next_st.step     = 1'b0;
    if (src_tick && !i_debug_halt) begin
      next_st.pre = st.pre + tpu_pkg::PRE_W'(1);
    end
    // counter
    if (tick) begin
      next_st.step = 1'b1;
      if (!st.center_aligned_pwm) begin
        if (st.cnt == top) begin
          cnt_next    = tpu_pkg::CNT_ZERO;
          next_st.tof = 1'b1;
        end else begin
          cnt_next = st.cnt + 16'h0001;
        end
      end else if (!st.down) begin
        if (st.cnt == top) begin
          cnt_next     = st.cnt - 16'h0001;
          next_st.down = 1'b1;
          next_st.tof  = 1'b1;
        end else begin
          cnt_next = st.cnt + 16'h0001;
        end
      end else begin
        if (st.cnt == tpu_pkg::CNT_ZERO) begin
          cnt_next     = st.cnt + 16'h0001;
          next_st.down = 1'b0;
        end else begin
          cnt_next = st.cnt - 16'h0001;
        end
      end
      pwm_load = (cnt_next == top) && (!st.center_aligned_pwm || !st.down);
      tof_set  = (st.cnt == top) && (!st.center_aligned_pwm || !st.down);
    end
    next_st.cnt = cnt_next;
    // channels
    for (int n = 0; n < tpu_pkg::NUM_CH; n++) begin
      next_st.ch[n].pin_sync = {st.ch[n].pin_sync[1:0], i_ch_pin[n]};
      pin_r = st.ch[n].pin_sync[1] & ~st.ch[n].pin_sync[2];
      pin_f = ~st.ch[n].pin_sync[1] & st.ch[n].pin_sync[2];
      hit   = st.step && (st.cnt == st.ch[n].val);
      next_st.ch[n].flag = 1'b0;                            // collect set events only
      if (st.center_aligned_pwm) begin
        if (hit) begin
          next_st.ch[n].flag = 1'b1;
          next_st.ch[n].out  = st.down ? ~st.ch[n].els[0] : st.ch[n].els[0];
        end
        if (pwm_load) begin
          next_st.ch[n].val = st.ch[n].pend;
        end
      end else if (st.ch[n].mode == tpu_pkg::MODE_CAP) begin
        if (((st.ch[n].els == tpu_pkg::ELS_RISE) && pin_r) ||
            ((st.ch[n].els == tpu_pkg::ELS_FALL) && pin_f) ||
            ((st.ch[n].els == tpu_pkg::ELS_ANY) && (pin_r || pin_f))) begin
          next_st.ch[n].val  = st.cnt;
          next_st.ch[n].flag = 1'b1;
        end
      end else if (st.ch[n].mode == tpu_pkg::MODE_CMP) begin
        if (hit) begin
          next_st.ch[n].flag = 1'b1;
          unique case (st.ch[n].els)
            tpu_pkg::ACT_TGL: next_st.ch[n].out = ~st.ch[n].out;
            tpu_pkg::ACT_CLR: next_st.ch[n].out = 1'b0;
            tpu_pkg::ACT_SET: next_st.ch[n].out = 1'b1;
            default:          next_st.ch[n].out = st.ch[n].out;
          endcase
        end
      end else begin
        if (st.step && st.cnt == tpu_pkg::CNT_ZERO) begin
          next_st.ch[n].out = ~st.ch[n].els[0];
        end
        if (hit) begin
          next_st.ch[n].flag = 1'b1;
          next_st.ch[n].out  = st.ch[n].els[0];
        end
        if (pwm_load) begin
          next_st.ch[n].val = st.ch[n].pend;
        end
      end
      ch_set[n]          = next_st.ch[n].flag;
      next_st.ch[n].flag = st.ch[n].flag | ch_set[n];
    end
    // bus write side
    if (i_axi.awvalid && !st.aw_got && st.bstate == tpu_pkg::TPU_IDLE) begin
      next_st.aw_got = 1'b1;
      next_st.waddr  = i_axi.awaddr;
    end
    if (i_axi.wvalid && !st.w_got && st.bstate == tpu_pkg::TPU_IDLE) begin
      next_st.w_got = 1'b1;
      next_st.wdata = i_axi.wdata;
      next_st.wstrb = i_axi.wstrb;
    end
    if (wr_fire) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bstate = tpu_pkg::TPU_RESP;
      wr_hit         = 1'b1;
      if (st.waddr == tpu_pkg::OFF_SC) begin
        if (st.wstrb[0]) begin
          if (st.wdata[tpu_pkg::SC_TOF] && !tof_set) begin
            next_st.tof = 1'b0;
          end
          next_st.toie    = st.wdata[tpu_pkg::SC_TOIE];
          next_st.center_aligned_pwm    = st.wdata[tpu_pkg::SC_CENTER_ALIGNED_PWM];
          next_st.clk_sel = st.wdata[tpu_pkg::SC_CLK +: 2];
          next_st.ps      = st.wdata[tpu_pkg::SC_PS +: 3];
        end
      end else if (st.waddr == tpu_pkg::OFF_CNT) begin
        if (st.wstrb[1:0] != 2'h0) begin
          next_st.cnt  = tpu_pkg::CNT_ZERO;
          next_st.pre  = '0;
          next_st.down = 1'b0;
        end
      end else if (st.waddr == tpu_pkg::OFF_MOD) begin
        if (st.wstrb[0]) next_st.modv[7:0] = st.wdata[7:0];
        if (st.wstrb[1]) next_st.modv[15:8] = st.wdata[15:8];
      end else begin
        wr_hit = 1'b0;
        for (int n = 0; n < tpu_pkg::NUM_CH; n++) begin
          off = tpu_pkg::OFF_CH_BASE + tpu_pkg::ADDR_W'(n) * tpu_pkg::OFF_CH_STEP;
          if (st.waddr == off) begin
            wr_hit = 1'b1;
            if (st.wstrb[0]) begin
              if (st.wdata[tpu_pkg::CC_FLAG] && !ch_set[n]) begin
                next_st.ch[n].flag = 1'b0;
              end
              next_st.ch[n].ie   = st.wdata[tpu_pkg::CC_IE];
              next_st.ch[n].mode = st.wdata[tpu_pkg::CC_MODE +: 2];
              next_st.ch[n].els  = st.wdata[tpu_pkg::CC_ELS +: 2];
            end
          end else if (st.waddr == off + tpu_pkg::OFF_CH_VAL) begin
            wr_hit = 1'b1;
            if (st.wstrb[0]) next_st.ch[n].pend[7:0] = st.wdata[7:0];
            if (st.wstrb[1]) next_st.ch[n].pend[15:8] = st.wdata[15:8];
            if (!st.center_aligned_pwm && !st.ch[n].mode[1]) begin
              if (st.wstrb[0]) next_st.ch[n].val[7:0] = st.wdata[7:0];
              if (st.wstrb[1]) next_st.ch[n].val[15:8] = st.wdata[15:8];
            end
          end
        end
      end
      next_st.bresp = wr_hit ? tpu_pkg::RESP_OK : tpu_pkg::RESP_ERR;
    end
    if (st.bstate == tpu_pkg::TPU_RESP && i_axi.bready) begin
      next_st.bstate = tpu_pkg::TPU_IDLE;
    end
    // bus read side
    if (rd_fire) begin
      rd             = rd_word(st, i_axi.araddr);
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd[31:0];
      next_st.rresp  = rd[32] ? tpu_pkg::RESP_ERR : tpu_pkg::RESP_OK;
    end else if (st.rvalid && i_axi.rready) begin
      next_st.rvalid = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_comb begin
    o_axi.awready = ~st.aw_got & (st.bstate == tpu_pkg::TPU_IDLE);
    o_axi.wready  = ~st.w_got & (st.bstate == tpu_pkg::TPU_IDLE);
    o_axi.bvalid  = (st.bstate == tpu_pkg::TPU_RESP);
    o_axi.bresp   = st.bresp;
    o_axi.arready = ~st.rvalid;
    o_axi.rvalid  = st.rvalid;
    o_axi.rdata   = st.rdata;
    o_axi.rresp   = st.rresp;
    o_ovf_irq     = st.tof & st.toie;
    for (int n = 0; n < tpu_pkg::NUM_CH; n++) begin
      o_ch_irq[n] = st.ch[n].flag & st.ch[n].ie;
      o_ch_pin[n] = st.ch[n].out;
      o_ch_oe[n]  = (st.clk_sel != tpu_pkg::CLK_NONE) && (st.ch[n].els != tpu_pkg::ELS_OFF) &&
                    (st.center_aligned_pwm || st.ch[n].mode != tpu_pkg::MODE_CAP);
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  a_write_resp_next: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    wr_fire |=> o_axi.bvalid)
    else $error("write not answered next cycle");
  a_debug_holds_cnt: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_debug_halt && !wr_fire) |=> $stable(st.cnt))
    else $error("counter moved in debug halt");
  a_clk_off_holds: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (st.clk_sel == tpu_pkg::CLK_NONE && !wr_fire) |=> $stable(st.cnt))
    else $error("counter moved with no clock");
  a_up_wrap_zero: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (tick && !st.center_aligned_pwm && st.cnt == top && !wr_fire) |=> (st.cnt == 16'h0000 && st.tof))
    else $error("up count did not wrap with overflow");
  a_center_turns: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (tick && st.center_aligned_pwm && !st.down && st.cnt == top && !wr_fire) |=> st.down ##0
    (st.cnt == $past(st.cnt) - 16'h0001))
    else $error("center count did not turn down");
  a_pins_off_idle: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (st.clk_sel == tpu_pkg::CLK_NONE) |-> (o_ch_oe == '0))
    else $error("pin driven with timer off");
  a_capture_copy: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!st.center_aligned_pwm && st.ch[0].mode == tpu_pkg::MODE_CAP && st.ch[0].els == tpu_pkg::ELS_RISE &&
     st.ch[0].pin_sync[1] && !st.ch[0].pin_sync[2]) |=>
    (st.ch[0].val == $past(st.cnt) && st.ch[0].flag))
    else $error("capture missed counter value");
  a_pwm_lead_edge: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!st.center_aligned_pwm && st.ch[0].mode[1] && st.step && st.cnt == 16'h0000 &&
     st.ch[0].val != 16'h0000) |=> (o_ch_pin[0] == ~$past(st.ch[0].els[0])))
    else $error("pwm leading edge wrong");
  a_tof_set_wins: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (tick && st.cnt == top && (!st.center_aligned_pwm || !st.down)) |=> st.tof)
    else $error("overflow set lost to clear");
endmodule : tpu_timer
`default_nettype wire

/* File: design/tpu_pkg.sv */
// Purpose: constants and types for the timer pulse unit
// Assumes: AXI4-Lite slave, 32-bit data, 8-bit byte address
// Notes:   offsets are byte addresses, one word per register
`default_nettype none
package tpu_pkg;
  // ****************************************
  // sizes
  // ****************************************
  localparam int NUM_CH = 2;
  localparam int CNT_W  = 16;
  localparam int ADDR_W = 8;
  localparam int PRE_W  = 7;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [ADDR_W-1:0] OFF_SC      = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CNT     = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_MOD     = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CH_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_CH_VAL  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CH_STEP = 8'h08;
  // ****************************************
  // field positions
  // ****************************************
  localparam int SC_TOF  = 7;
  localparam int SC_TOIE = 6;
  localparam int SC_CENTER_ALIGNED_PWM = 5;
  localparam int SC_CLK  = 3;
  localparam int SC_PS   = 0;
  localparam int CC_FLAG = 7;
  localparam int CC_IE   = 6;
  localparam int CC_MODE = 4;
  localparam int CC_ELS  = 2;
  // ****************************************
  // values
  // ****************************************
  localparam logic [1:0]       CLK_NONE = 2'h0;
  localparam logic [1:0]       CLK_BUS  = 2'h1;
  localparam logic [1:0]       CLK_FIX  = 2'h2;
  localparam logic [1:0]       CLK_EXT  = 2'h3;
  localparam logic [1:0]       MODE_CAP = 2'h0;
  localparam logic [1:0]       MODE_CMP = 2'h1;
  localparam logic [1:0]       ELS_OFF  = 2'h0;
  localparam logic [1:0]       ELS_RISE = 2'h1;
  localparam logic [1:0]       ELS_FALL = 2'h2;
  localparam logic [1:0]       ELS_ANY  = 2'h3;
  localparam logic [1:0]       ACT_TGL  = 2'h1;
  localparam logic [1:0]       ACT_CLR  = 2'h2;
  localparam logic [1:0]       ACT_SET  = 2'h3;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_FULL = 16'hffff;
  localparam logic [1:0]       RESP_OK  = 2'h0;
  localparam logic [1:0]       RESP_ERR = 2'h2;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    TPU_IDLE = 2'b00,
    TPU_RESP = 2'b01
  } tpu_bus_state_t;
  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } tpu_axi_req_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } tpu_axi_rsp_t;
  typedef struct packed {
    logic             flag;
    logic             ie;
    logic [1:0]       mode;
    logic [1:0]       els;
    logic [CNT_W-1:0] val;
    logic [CNT_W-1:0] pend;
    logic             out;
    logic [2:0]       pin_sync;
  } tpu_ch_t;
  typedef struct packed {
    tpu_bus_state_t         bstate;
    logic                   aw_got;
    logic                   w_got;
    logic [ADDR_W-1:0]      waddr;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    logic                   tof;
    logic                   toie;
    logic                   center_aligned_pwm;
    logic [1:0]             clk_sel;
    logic [2:0]             ps;
    logic [CNT_W-1:0]       cnt;
    logic [CNT_W-1:0]       modv;
    logic [PRE_W-1:0]       pre;
    logic                   down;
    logic                   step;
    logic [2:0]             ext_sync;
    logic [2:0]             fix_sync;
    tpu_ch_t [NUM_CH-1:0]   ch;
  } tpu_state_t;
endpackage : tpu_pkg
`default_nettype wire

/* File: verif/tpu_pin_model.sv */
// Purpose: pin-side model for the timer pulse unit
// Assumes: count clocks are async to the bus clock
// Notes:   count clocks stand still while not enabled
`timescale 1ns/10ps
`default_nettype none
module tpu_pin_model (
  input  wire logic                       i_ext_en,
  input  wire logic                       i_fix_en,
  input  wire logic [tpu_pkg::NUM_CH-1:0] i_lvl,
  input  wire logic [tpu_pkg::NUM_CH-1:0] i_out,
  input  wire logic [tpu_pkg::NUM_CH-1:0] i_oe,
  output logic                            o_ext_clk,
  output logic                            o_fix_clk,
  output logic      [tpu_pkg::NUM_CH-1:0] o_pin
);
  // ****
  // count clocks and pin wires
  // ****
  initial begin
    o_ext_clk = 1'b0;
    o_fix_clk = 1'b0;
  end
  // external period 230 ns, under a quarter of the bus rate
  always #115 o_ext_clk = i_ext_en ? ~o_ext_clk : 1'b0;
  always #65 o_fix_clk = i_fix_en ? ~o_fix_clk : 1'b0;
  // timer drive wins, else the far-side level
  assign o_pin = (i_oe & i_out) | (~i_oe & i_lvl);
endmodule : tpu_pin_model
`default_nettype wire

/* File: verif/tb_timer_pwm_capture_unit.sv */
// Purpose: self-checking bench for the timer pulse unit
// Assumes: AXI4-Lite master tasks, pin model on the channel pins
// Notes:   count checks allow a few ticks of bus latency
`timescale 1ns/10ps
`default_nettype none
module tb_timer_pwm_capture_unit;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [1:0]  resp;
  } tpu_row_t;
  localparam tpu_row_t ROWS [10] = '{
    '{tpu_pkg::OFF_SC, 32'h000000c7, 32'h00000047, 2'h0},
    '{tpu_pkg::OFF_MOD, 32'hffff1234, 32'h00001234, 2'h0},
    '{8'h14, 32'h0000beef, 32'h0000beef, 2'h0},
    '{8'h18, 32'h000000d4, 32'h00000054, 2'h0},
    '{tpu_pkg::OFF_CNT, 32'h00000055, 32'h00000000, 2'h0},
    '{8'h20, 32'h00000001, 32'h00000000, tpu_pkg::RESP_ERR},
    '{8'h40, 32'h00000001, 32'h00000000, tpu_pkg::RESP_ERR},
    '{tpu_pkg::OFF_SC, 32'h00000000, 32'h00000000, 2'h0},
    '{8'h18, 32'h00000000, 32'h00000000, 2'h0},
    '{tpu_pkg::OFF_MOD, 32'h00000000, 32'h00000000, 2'h0}};
  logic                  clk, rst, halt, ovf, ext_en, fix_en, ext_clk, fix_clk, p;
  tpu_pkg::tpu_axi_req_t ax;
  tpu_pkg::tpu_axi_rsp_t rs;
  logic [1:0]            pin_in, pin_out, oe, chirq, lvl, r;
  logic [31:0]           q;
  int                    failures, checks_done, cyc, hi, ed;
  // ****
  // design and pin model
  // ****
  tpu_timer DUT (.i_ref_clk(clk), .i_rst(rst), .i_axi(ax), .o_axi(rs),
    .i_debug_halt(halt), .i_fixed_clk(fix_clk), .i_ext_clk(ext_clk), .i_ch_pin(pin_in),
    .o_ch_pin(pin_out), .o_ch_oe(oe), .o_ovf_irq(ovf), .o_ch_irq(chirq));
  tpu_pin_model u_pins (.i_ext_en(ext_en), .i_fix_en(fix_en), .i_lvl(lvl), .i_out(pin_out),
    .i_oe(oe), .o_ext_clk(ext_clk), .o_fix_clk(fix_clk), .o_pin(pin_in));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      conclude();
    end
  end
  // ****
  // tasks
  // ****
  task conclude();
    if (failures == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", n, e, g);
      failures++;
    end
  endtask : chk
  task rng(input string n, input int lo, input int up, input logic [31:0] g);
    checks_done++;
    if ((g >= lo && g <= up) !== 1'b1) begin
      $display("[ERR] %s exp %0d..%0d got %h", n, lo, up, g);
      failures++;
    end
  endtask : rng
  task axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    ax.awaddr <= a;
    ax.wdata <= d;
    ax.wstrb <= 4'hf;
    ax.awvalid <= 1'b1;
    ax.wvalid <= 1'b1;
    ax.bready <= 1'b1;
    do begin
      @(posedge clk);
      if (rs.awready) ax.awvalid <= 1'b0;
      if (rs.wready) ax.wvalid <= 1'b0;
    end while (rs.bvalid !== 1'b1);
    r = rs.bresp;
    ax.bready <= 1'b0;
  endtask : axw
  task axr(input logic [7:0] a);
    @(posedge clk);
    ax.araddr <= a;
    ax.arvalid <= 1'b1;
    ax.rready <= 1'b1;
    do begin
      @(posedge clk);
      if (rs.arready) ax.arvalid <= 1'b0;
    end while (rs.rvalid !== 1'b1);
    q = rs.rdata;
    r = rs.rresp;
    ax.rready <= 1'b0;
  endtask : axr
  task cnt_after(input logic [7:0] sc, input int n);
    axw(tpu_pkg::OFF_SC, {24'h0, sc});
    axw(tpu_pkg::OFF_CNT, 32'h0);
    repeat (n) @(posedge clk);
    axr(tpu_pkg::OFF_CNT);
  endtask : cnt_after
  task hcount(input int n);
    hi = 0;
    ed = 0;
    p = pin_out[0];
    repeat (n) begin
      @(posedge clk);
      hi += pin_out[0];
      ed += (pin_out[0] && !p);
      p = pin_out[0];
    end
  endtask : hcount
  // ****
  // main sequence
  // ****
  initial begin
    rst = 1'b1;
    halt = 1'b0;
    ax = '0;
    lvl = 2'h0;
    ext_en = 1'b0;
    fix_en = 1'b0;
    failures = 0;
    checks_done = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    axr(tpu_pkg::OFF_SC);
    chk("sc_rst", 32'h0, q);
    chk("oe_rst", 32'h0, oe);
    foreach (ROWS[i]) begin
      axw(ROWS[i].addr, ROWS[i].wdata);
      chk("wresp", ROWS[i].resp, r);
      axr(ROWS[i].addr);
      chk("rdata", ROWS[i].rdata, q);
      chk("rresp", ROWS[i].resp, r);
    end
    for (int s = 0; s < 8; s++) begin
      cnt_after({3'h0, tpu_pkg::CLK_BUS, s[2:0]}, 256);
      rng("cnt_ps", 256 >> s, (256 >> s) + 4, q);
    end
    fix_en <= 1'b1;
    cnt_after({3'h0, tpu_pkg::CLK_FIX, 3'h0}, 256);
    rng("cnt_fix", 46, 52, q);
    fix_en <= 1'b0;
    ext_en <= 1'b1;
    cnt_after({3'h0, tpu_pkg::CLK_EXT, 3'h0}, 256);
    rng("cnt_ext", 25, 31, q);
    ext_en <= 1'b0;
    cnt_after(8'h00, 64);
    chk("cnt_none", 32'h0, q);
    halt <= 1'b1;
    cnt_after(8'h08, 64);
    chk("cnt_halt", 32'h0, q);
    halt <= 1'b0;
    axw(tpu_pkg::OFF_MOD, 32'h5);
    cnt_after(8'h48, 20);
    rng("cnt_wrap", 0, 5, q);
    chk("ovf_irq", 32'h1, ovf);
    axw(tpu_pkg::OFF_SC, 32'h80);
    axr(tpu_pkg::OFF_SC);
    chk("tof_clr", 32'h0, q);
    axw(tpu_pkg::OFF_MOD, 32'h0);
    axw(8'h10, 32'h44);
    cnt_after(8'h08, 50);
    lvl[0] <= 1'b1;
    repeat (10) @(posedge clk);
    chk("cap_irq", 32'h1, chirq[0]);
    axr(8'h14);
    rng("cap_val", 52, 70, q);
    axw(8'h10, 32'hc4);
    lvl[0] <= 1'b0;
    repeat (10) @(posedge clk);
    chk("cap_fall", 32'h0, chirq[0]);
    for (int a = 3; a >= 0; a--) begin
      axw(8'h18, {24'h0, 4'h9, a[1:0], 2'h0});
      axw(8'h1c, 32'h40);
      cnt_after(8'h08, 100);
      axr(8'h18);
      chk("cmp_flag", 32'h1, q[7]);
      chk("cmp_oe", a != 0, oe[1]);
      if (a != 0) chk("cmp_pin", a != 2, pin_out[1]);
    end
    axw(8'h18, 32'h80);
    axw(tpu_pkg::OFF_MOD, 32'h9);
    axw(tpu_pkg::OFF_CNT, 32'h0);
    for (int e = 1; e <= 2; e++) begin
      axw(8'h10, {26'h0, 2'h2, e[1:0], 2'h0});
      axw(8'h14, 32'h3);
      hcount(40);
      hcount(100);
      chk("edge_aligned_pwm_hi", (e == 2) ? 30 : 70, hi);
      chk("edge_aligned_pwm_ed", 32'd10, ed);
    end
    axw(tpu_pkg::OFF_MOD, 32'h8);
    axw(8'h10, 32'h08);
    axw(8'h14, 32'h3);
    axw(8'h18, 32'h04);
    axw(tpu_pkg::OFF_SC, 32'h28);
    axw(tpu_pkg::OFF_CNT, 32'h0);
    hcount(64);
    hcount(160);
    chk("center_aligned_pwm_hi", 32'd60, hi);
    chk("center_aligned_pwm_ed", 32'd10, ed);
    chk("center_aligned_pwm_oe", 32'h3, oe);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("oe_rst2", 32'h0, oe);
    conclude();
  end
endmodule : tb_timer_pwm_capture_unit
`default_nettype wire
